// File: test/rps_sequencer_assertions.sv
// Port checks for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer_assertions #(parameter longint DEF_CYCLES = 20) (
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic I_MASTER_RESET_IN_N,
	input wire logic I_POWER_GOOD_RESET_IN_N,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic O_WB_ACK,
	input wire logic O_SYSTEM_RESET_OUT,
	input wire logic O_CORE_CLK_GATE,
	input wire logic O_PULLDOWN_FORCE,
	input wire logic O_RTC_RESET,
	input wire logic O_PROG_PIN_TWO_OE,
	input wire logic O_PROG_PIN_THREE_OE
);
	logic   both_hi;
	longint hi_cnt;
	assign both_hi = I_MASTER_RESET_IN_N && I_POWER_GOOD_RESET_IN_N;
	always_ff @(posedge I_SYS_CLK) hi_cnt <= (I_RST || !both_hi) ? 0 : hi_cnt + 1;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	sequence wb_req; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
	sequence pins_idle; both_hi [*3]; endsequence
	pins_low_a: assert property (!both_hi |-> ##3 O_SYSTEM_RESET_OUT && O_PULLDOWN_FORCE)
		else $error("reset out or force late");
	force_idle_a: assert property (pins_idle |=> !O_PULLDOWN_FORCE)
		else $error("force stuck");
	hold_timer_a: assert property ($fell(O_SYSTEM_RESET_OUT) |-> hi_cnt >= DEF_CYCLES)
		else $error("reset out released early");
	gate_match_a: assert property (O_CORE_CLK_GATE == O_SYSTEM_RESET_OUT)
		else $error("clock gate differs");
	rtc_master_a: assert property (!I_MASTER_RESET_IN_N |-> ##3 O_RTC_RESET)
		else $error("rtc reset missing");
	rtc_spare_a: assert property (I_MASTER_RESET_IN_N [*3] |=> !O_RTC_RESET)
		else $error("rtc reset spurious");
	ack_answer_a: assert property (wb_req |=> O_WB_ACK)
		else $error("ack missing");
	ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack too long");
	pin_oe_a: assert property (O_PROG_PIN_TWO_OE || O_PROG_PIN_THREE_OE |-> O_PULLDOWN_FORCE)
		else $error("pin enable outside power off");
endmodule // rps_sequencer_assertions
bind rps_sequencer rps_sequencer_assertions #(.DEF_CYCLES(DEF_CYCLES)) chk_u (.*);
`default_nettype wire

// File: test/rps_sequencer_tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer_tb import rps_pkg::*; ;
	logic        clk, rst, cyc, stb, we, mr_n, pg_n, mr_req, pg_req;
	logic        ack, ro, gate, frc, rtc, p2, p2e, p3, p3e;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] wd, rd, q;
	logic [3:0]  rows [4] = '{4'hF, 4'h6, 4'hB, 4'h0};
	int          fails = 0, cmp_count = 0, tick = 0, n;
	rps_supervisor_model #(.MIN_HOLD(30)) sup_u (.i_clk(clk), .i_shared(1'b0),
		.i_mr_req(mr_req), .i_pg_req(pg_req), .o_mr_n(mr_n), .o_pg_n(pg_n));
	rps_sequencer #(.DEF_CYCLES(20), .CYC_PER_MS(5)) dut_u (.I_SYS_CLK(clk), .I_RST(rst),
		.I_MASTER_RESET_IN_N(mr_n), .I_POWER_GOOD_RESET_IN_N(pg_n), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wd),
		.O_WB_DAT(rd), .O_WB_ACK(ack), .O_SYSTEM_RESET_OUT(ro), .O_CORE_CLK_GATE(gate),
		.O_PULLDOWN_FORCE(frc), .O_RTC_RESET(rtc), .O_PROG_PIN_TWO(p2),
		.O_PROG_PIN_TWO_OE(p2e), .O_PROG_PIN_THREE(p3), .O_PROG_PIN_THREE_OE(p3e));
	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hF};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		r = rd;
		if (k == 20) fails++;
		{cyc, stb} <= 2'b00;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		tick <= tick + 1;
		if (tick == 6000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		{cyc, stb, we, adr, sel, wd, mr_req, pg_req} = '0;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk);
			{mr_req, pg_req} <= rows[i][3:2];
			repeat (80) @(posedge clk);
			chk("force", rows[i][1], frc);
			chk("rtc", rows[i][0], rtc);
			chk("rst_out", rows[i][1], ro);
			chk("gate", rows[i][1], gate);
		end
		wb(1'b0, RPS_ADR_STATUS, 0, q);
		chk("status", {26'h0000000, RPS_ST_RUN, 4'h3}, q);
		wb(1'b0, RPS_ADR_CLOCK_CONTROL, 0, q); chk("cc", RPS_CC_RESET, q);
		wb(1'b1, RPS_ADR_CLOCK_CONTROL, 32'h2, q);
		wb(1'b1, RPS_ADR_PGP_CTRL, 32'hF, q);
		wb(1'b1, 12'h100, 32'hFF, q);
		wb(1'b0, 12'h100, 0, q); chk("unmapped", 0, q);
		@(posedge clk);
		pg_req <= 1'b1;
		repeat (10) @(posedge clk);
		chk("pins", 4'hF, {p3e, p3, p2e, p2});
		pg_req <= 1'b0;
		n = 0;
		while (ro !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("timer", 1, n >= 40 && n <= 50);
		wb(1'b0, RPS_ADR_CLOCK_CONTROL, 0, q); chk("cc_kept", 32'h2, q);
		mr_req <= 1'b1;
		repeat (10) @(posedge clk);
		wb(1'b1, RPS_ADR_CLOCK_CONTROL, 32'h5, q);
		mr_req <= 1'b0;
		repeat (100) @(posedge clk);
		wb(1'b0, RPS_ADR_CLOCK_CONTROL, 0, q); chk("cc_def", RPS_CC_RESET, q);
		wb(1'b0, RPS_ADR_PGP_CTRL, 0, q); chk("pgp_def", RPS_PGP_RESET, q);
		// Mid-run reset: outputs asserted during it, clock control register back to its default after
		wb(1'b1, RPS_ADR_CLOCK_CONTROL, 32'h2, q);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("rst_ro", 1, ro);
		chk("rst_frc", 1, frc);
		chk("rst_rtc", 1, rtc);
		chk("rst_ack", 0, ack);
		rst <= 1'b0;
		repeat (60) @(posedge clk);
		chk("rst_ro_rel", 0, ro);
		wb(1'b0, RPS_ADR_CLOCK_CONTROL, 0, q); chk("cc_rst", RPS_CC_RESET, q);
		tally_and_finish();
	end
endmodule // rps_sequencer_tb
`default_nettype wire

// File: test/rps_supervisor_model.sv
// Supervisor model driving both reset pins
`timescale 1ns/1ps
`default_nettype none
module rps_supervisor_model #(parameter int MIN_HOLD = 30) (
	input  wire logic i_clk,
	input  wire logic i_shared,
	input  wire logic i_mr_req,
	input  wire logic i_pg_req,
	output logic      o_mr_n = 1'b0,
	output logic      o_pg_n = 1'b0
);
	int   held = 0;
	logic mr_nx;
	assign mr_nx = !i_mr_req && (o_mr_n || held >= MIN_HOLD);
	always @(posedge i_clk) begin
		held <= o_mr_n ? 0 : held + 1;
		o_mr_n <= mr_nx;
		o_pg_n <= i_shared ? mr_nx : !i_pg_req;
	end
endmodule // rps_supervisor_model
`default_nettype wire

// File: verilog/rps_pkg.sv
// Package with register map, field layout and timing constants for the reset sequencer
package rps_pkg;

	// Register byte offsets (index times four)
	localparam logic [7:0]  RPS_IDX_CLOCK_CONTROL = 8'h8F;
	localparam logic [11:0] RPS_ADR_CLOCK_CONTROL = 12'h23C;
	localparam logic [11:0] RPS_ADR_STATUS        = 12'h000;
	localparam logic [11:0] RPS_ADR_PGP_CTRL      = 12'h004;

	// Clock control fields
	localparam int          RPS_CC_TIMER_LSB = 0;
	localparam int          RPS_CC_TIMER_W   = 3;
	localparam logic [7:0]  RPS_CC_RESET     = 8'h00;

	// Programmable pin control reset value
	localparam logic [7:0]  RPS_PGP_RESET    = 8'h00;

	// Timing
	localparam longint      RPS_CLK_HZ       = 200000000;
	localparam longint      RPS_TIMER_MS_4   = 4;
	localparam longint      RPS_CYC_PER_MS   = RPS_CLK_HZ / 1000;
	localparam longint      RPS_DEF_CYCLES   = RPS_TIMER_MS_4 * RPS_CYC_PER_MS;

	// Synchroniser input pair
	typedef struct packed {
		logic master_reset_n;
		logic power_good_n;
	} rps_in_s;

	typedef enum logic [1:0] {
		RPS_ST_RESET = 2'b00,
		RPS_ST_COUNT = 2'b01,
		RPS_ST_RUN   = 2'b10
	} rps_state_e;

endpackage : rps_pkg

// File: verilog/rps_sequencer.sv
// Reset output and pulldown sequencer with Wishbone register access
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer
	import rps_pkg::*;
#(
	parameter longint DEF_CYCLES = RPS_DEF_CYCLES,
	parameter longint CYC_PER_MS = RPS_CYC_PER_MS
) (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_MASTER_RESET_IN_N,
	input  wire logic        I_POWER_GOOD_RESET_IN_N,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [11:0] I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	output logic             O_SYSTEM_RESET_OUT,
	output logic             O_CORE_CLK_GATE,
	output logic             O_PULLDOWN_FORCE,
	output logic             O_RTC_RESET,
	output logic             O_PROG_PIN_TWO,
	output logic             O_PROG_PIN_TWO_OE,
	output logic             O_PROG_PIN_THREE,
	output logic             O_PROG_PIN_THREE_OE
);

	localparam int CW = 36;

	rps_in_s    raw;
	rps_in_s    syn;
	logic       both_high;
	logic       master_act;

	rps_state_e state_reg;
	rps_state_e state_next;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic [CW-1:0] target;

	logic [7:0] cc_reg;
	logic [7:0] cc_next;
	logic [7:0] pgp_reg;
	logic [7:0] pgp_next;
	logic       ack_reg;
	logic       ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic       rst_out_reg;
	logic       rst_out_next;
	logic       force_reg;
	logic       force_next;
	logic       rtc_reg;
	logic       rtc_next;
	logic       req;

	assign raw.master_reset_n = I_MASTER_RESET_IN_N;
	assign raw.power_good_n   = I_POWER_GOOD_RESET_IN_N;

	rps_sync u_sync (
		.I_SYS_CLK (I_SYS_CLK),
		.I_RST     (I_RST),
		.i_async   (raw),
		.o_sync    (syn)
	);

	// Only 1,1 is normal operation; 1,0 falls into the same branch as 0,0
	assign both_high  = syn.master_reset_n & syn.power_good_n;
	assign master_act = ~syn.master_reset_n;

	// Timer field 0 means default 4 ms, otherwise field value in milliseconds times 4
	always_comb begin
		if (cc_reg[RPS_CC_TIMER_LSB +: RPS_CC_TIMER_W] == '0) begin
			target = CW'(DEF_CYCLES);
		end else begin
			target = CW'(longint'(cc_reg[RPS_CC_TIMER_LSB +: RPS_CC_TIMER_W]) * 4 * CYC_PER_MS);
		end
	end

	// Sequencer next state
	always_comb begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		if (!both_high) begin
			state_next = RPS_ST_RESET;
			cnt_next   = '0;
		end else begin
			unique case (state_reg)
				RPS_ST_RESET: begin
					state_next = RPS_ST_COUNT;
					cnt_next   = '0;
				end
				RPS_ST_COUNT: begin
					if (cnt_reg + CW'(1) >= target) begin
						state_next = RPS_ST_RUN;
					end else begin
						cnt_next = cnt_reg + CW'(1);
					end
				end
				RPS_ST_RUN: begin
					state_next = RPS_ST_RUN;
				end
				default: begin
					state_next = RPS_ST_RESET;
				end
			endcase
		end
		rst_out_next = (state_next != RPS_ST_RUN);
		force_next   = ~both_high;
		rtc_next     = master_act;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			state_reg   <= RPS_ST_RESET;
			cnt_reg     <= '0;
			rst_out_reg <= 1'b1;
			force_reg   <= 1'b1;
			rtc_reg     <= 1'b1;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			rst_out_reg <= rst_out_next;
			force_reg   <= force_next;
			rtc_reg     <= rtc_next;
		end
	end

	// Register bus next values
	assign req = I_WB_CYC & I_WB_STB & ~ack_reg;

	always_comb begin
		cc_next  = cc_reg;
		pgp_next = pgp_reg;
		dat_next = dat_reg;
		ack_next = req;
		if (master_act) begin
			cc_next  = RPS_CC_RESET;
			pgp_next = RPS_PGP_RESET;
		end else if (req && I_WB_WE && I_WB_SEL[0]) begin
			unique case (I_WB_ADR)
				RPS_ADR_CLOCK_CONTROL: cc_next  = I_WB_DAT[7:0];
				RPS_ADR_PGP_CTRL:      pgp_next = I_WB_DAT[7:0];
				default: begin
				end
			endcase
		end
		if (req && !I_WB_WE) begin
			unique case (I_WB_ADR)
				RPS_ADR_CLOCK_CONTROL: dat_next = {24'h000000, cc_reg};
				RPS_ADR_PGP_CTRL:      dat_next = {24'h000000, pgp_reg};
				RPS_ADR_STATUS: dat_next = {26'h0000000, state_reg, force_reg, rst_out_reg,
					syn.power_good_n, syn.master_reset_n};
				default:               dat_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			cc_reg  <= RPS_CC_RESET;
			pgp_reg <= RPS_PGP_RESET;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			cc_reg  <= cc_next;
			pgp_reg <= pgp_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign O_WB_ACK           = ack_reg;
	assign O_WB_DAT           = dat_reg;
	assign O_SYSTEM_RESET_OUT = rst_out_reg;
	assign O_CORE_CLK_GATE    = rst_out_reg;
	assign O_PULLDOWN_FORCE   = force_reg;
	assign O_RTC_RESET        = rtc_reg;
	// Preset pin states apply while the pulldown force is active
	assign O_PROG_PIN_TWO      = pgp_reg[0];
	assign O_PROG_PIN_TWO_OE   = force_reg & pgp_reg[1];
	assign O_PROG_PIN_THREE    = pgp_reg[2];
	assign O_PROG_PIN_THREE_OE = force_reg & pgp_reg[3];

endmodule // rps_sequencer
`default_nettype wire

// File: verilog/rps_sync.sv
// Two flip-flop synchroniser for the reset input pair
`timescale 1ns/1ps
`default_nettype none
module rps_sync
	import rps_pkg::*;
(
	input  wire logic    I_SYS_CLK,
	input  wire logic    I_RST,
	input  wire rps_in_s i_async,
	output var  rps_in_s o_sync
);

	rps_in_s meta_reg;
	rps_in_s meta_next;
	rps_in_s sync_reg;
	rps_in_s sync_next;

	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	// Resets to the asserted (low) level so release is always clean
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;

endmodule // rps_sync
`default_nettype wire
